// File: hw/mpp_unit.sv
// Protection unit: privilege level, area limits, pointer prefetch and checks
`timescale 1ns/10ps
module mpp_unit (
    // Clock and reset
    input  wire logic core_clk,
    input  wire logic rst_n,
    // Core side
    mpp_link_if.unit  lnk,
    // Boot control
    input  wire logic pwBlankClr,
    input  wire logic faultIntEn,
    output logic      protect_enable,
    output logic      debugSysLock,
    output logic [mpp_pkg::MPP_PGW-1:0] loaderPage,
    output logic [mpp_pkg::MPP_PGW-1:0] appPage
);
    import mpp_pkg::*;

    logic [MPP_PVW-1:0] priv_r;
    logic [MPP_PGW-1:0] ldr_r;
    logic [MPP_PGW-1:0] app_r;
    logic               mpe_r;
    logic [MPP_DW-1:0]  held_r;
    logic               heldOk_r;
    logic               pend_r;
    logic               pendBad_r;
    logic               exc_r;
    logic               flt_r;
    logic [MPP_PVW-1:0] maxIp;
    logic [MPP_PVW-1:0] maxTgt;
    logic [MPP_PGW-1:0] ipPage;
    logic [MPP_PGW-1:0] tgtPage;
    logic               wrTooHigh;
    logic               actBad;
    logic               isSysTgt;
    logic               isLdrTgt;
    logic               actReq;

    // Page number of code addresses
    assign ipPage  = lnk.instructionPointer[MPP_AW-1:MPP_PAGE_LSB];
    assign tgtPage = lnk.actAddr[MPP_AW-1:MPP_PAGE_LSB];

    // Pointer activation aimed at a real pointer register
    assign actReq  = lnk.actValid && lnk.actTarget != MPP_TGT_NONE;

    // Maximum privilege of the executing area
    always_comb begin
        unique case (lnk.execSrc)
            MPP_SRC_ROM:   maxIp = MPP_PRIV_HIGH;
            MPP_SRC_RAM:   maxIp = MPP_PRIV_LOW;
            MPP_SRC_FLASH: begin
                if (ipPage < ldr_r) begin
                    maxIp = MPP_PRIV_HIGH;
                end else if (ipPage < app_r) begin
                    maxIp = MPP_PRIV_MED;
                end else begin
                    maxIp = MPP_PRIV_LOW;
                end
            end
            // Illegal source code: grant the least
            default:       maxIp = MPP_PRIV_LOW;
        endcase
    end

    // Write tries to exceed the area maximum
    // Any bit outside the area maximum counts as a raise attempt
    assign wrTooHigh = lnk.privWrValid && ((lnk.privWrData & ~maxIp) != '0);

    // Read permission needed for the target page
    assign isSysTgt = tgtPage < ldr_r;
    assign isLdrTgt = !isSysTgt && (tgtPage < app_r);
    assign maxTgt   = priv_r;

    // Activation check: flash low-range data is open, RAM low-range data and code reads judged by level, other data reads pass
    always_comb begin
        actBad = 1'b0;
        if (actReq && mpe_r) begin
            if (lnk.execSrc == MPP_SRC_FLASH && lnk.actAddr <= MPP_OPEN_TOP
                && !lnk.actIsCode) begin
                actBad = 1'b0;
            end else if (lnk.execSrc == MPP_SRC_RAM && !lnk.actIsCode
                && lnk.actAddr <= MPP_OPEN_TOP) begin
                actBad = isSysTgt && !maxTgt[MPP_BIT_SYS_RD];
            end else if (lnk.actIsCode) begin
                actBad = (isSysTgt && !maxTgt[MPP_BIT_SYS_RD])
                      || (isLdrTgt && !maxTgt[MPP_BIT_LDR_RD]);
            end
        end
    end

    // Privilege level: clamped to the area maximum every cycle, reset high
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            priv_r <= MPP_PRIV_HIGH;
        end else if (lnk.privWrValid && !wrTooHigh) begin
            priv_r <= lnk.privWrData;
        end else if (wrTooHigh) begin
            // No partial grant: a refused value leaves no trace
            priv_r <= priv_r & maxIp;
        end else begin
            priv_r <= priv_r & maxIp;
        end
    end

    // Loader boundary: needs the system write bit
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            ldr_r <= MPP_PAGE_RST;
        end else if (lnk.ldrWrValid && priv_r[MPP_BIT_SYS_WR]) begin
            ldr_r <= lnk.pageWrData;
        end
    end

    // Application boundary: needs the loader write bit, refusal keeps the page
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            app_r <= MPP_PAGE_RST;
        end else if (lnk.appWrValid && priv_r[MPP_BIT_LDR_WR]) begin
            app_r <= lnk.pageWrData;
        end
    end

    // Protection enable, cleared only for a blank password
    // Nothing sets it again before reset, so user code cannot toggle it
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            mpe_r <= 1'b1;
        end else if (pwBlankClr && priv_r == MPP_PRIV_HIGH
            && lnk.execSrc == MPP_SRC_ROM) begin
            mpe_r <= 1'b0;
        end
    end

    // Activation tracking: the array answers one cycle after the strobe
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            pend_r    <= 1'b0;
            pendBad_r <= 1'b0;
        end else begin
            pend_r    <= actReq;
            pendBad_r <= actBad;
        end
    end

    // Held word: a denied read leaves nothing usable behind
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            held_r   <= '0;
            heldOk_r <= 1'b0;
        end else if (pend_r) begin
            held_r   <= pendBad_r ? '0 : lnk.memRdata;
            heldOk_r <= !pendBad_r;
        end
    end

    // Privilege exception pulse, raised on a refused level write or a denied code read
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            exc_r <= 1'b0;
        end else begin
            exc_r <= wrTooHigh || (actBad && lnk.actIsCode);
        end
    end

    // Memory fault pulse, only while its interrupt is enabled
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            flt_r <= 1'b0;
        end else begin
            flt_r <= actBad && !lnk.actIsCode && faultIntEn;
        end
    end

    // Memory strobes: blocked when the check fails
    // Check and strobe share a cycle, so a denied read never reaches the array
    assign lnk.memCe    = actReq && !actBad;
    assign lnk.memRd    = lnk.memCe;
    assign lnk.memAddr  = lnk.actAddr;
    // Held word goes out on source use, no new read
    assign lnk.srcData  = held_r;
    assign lnk.srcValid = lnk.srcUse && heldOk_r;
    assign lnk.privDeny = wrTooHigh;
    assign lnk.privLevel = priv_r;
    assign lnk.privExc  = exc_r;
    assign lnk.memFault = flt_r;
    assign protect_enable = mpe_r;
    assign debugSysLock   = mpe_r;
    assign loaderPage     = ldr_r;
    assign appPage        = app_r;
endmodule

// File: hw/mpp_pkg.sv
// Package for the memory privilege protection block: levels, areas, widths
package mpp_pkg;
    // Widths
    localparam int MPP_AW  = 16;
    localparam int MPP_DW  = 16;
    localparam int MPP_PGW = 8;
    localparam int MPP_PVW = 4;
    // Privilege level encodings
    localparam logic [3:0] MPP_PRIV_HIGH = 4'h000f;
    localparam logic [3:0] MPP_PRIV_MED  = 4'h0003;
    localparam logic [3:0] MPP_PRIV_LOW  = 4'h0000;
    // Privilege bit positions
    localparam int MPP_BIT_SYS_WR = 3;
    localparam int MPP_BIT_SYS_RD = 2;
    localparam int MPP_BIT_LDR_WR = 1;
    localparam int MPP_BIT_LDR_RD = 0;
    // Boundary reset value: end of flash
    localparam logic [7:0] MPP_PAGE_RST = 8'h0080;
    // Page number position in a code address
    localparam int MPP_PAGE_LSB = 8;
    // Window in which flash-executing data accesses skip checks
    localparam logic [15:0] MPP_OPEN_TOP = 16'h7fff;
    // Where code is executing from
    typedef enum logic [2:0] {
        MPP_SRC_FLASH = 3'b001,
        MPP_SRC_ROM   = 3'b010,
        MPP_SRC_RAM   = 3'b100
    } mpp_src_t;
    // Pointer register targets of a write
    typedef enum logic [5:0] {
        MPP_TGT_NONE = 6'b000001,
        MPP_TGT_DP0  = 6'b000010,
        MPP_TGT_DP1  = 6'b000100,
        MPP_TGT_BASE = 6'b001000,
        MPP_TGT_DISP = 6'b010000,
        MPP_TGT_CTRL = 6'b100000
    } mpp_tgt_t;
endpackage

// File: hw/mpp_link_if.sv
// Interface joining the core execution end and the protection unit
`timescale 1ns/10ps
interface mpp_link_if;
    import mpp_pkg::*;
    // Privilege register writes
    logic                privWrValid;
    logic [MPP_PVW-1:0]  privWrData;
    logic                privDeny;
    logic [MPP_PVW-1:0]  privLevel;
    // Boundary writes
    logic                ldrWrValid;
    logic                appWrValid;
    logic [MPP_PGW-1:0]  pageWrData;
    // Execution context
    mpp_src_t            execSrc;
    logic [MPP_AW-1:0]   instructionPointer;
    // Pointer activation
    logic                actValid;
    mpp_tgt_t            actTarget;
    logic [MPP_AW-1:0]   actAddr;
    logic                actIsCode;
    // Pointer used as source
    logic                srcUse;
    logic [MPP_DW-1:0]   srcData;
    logic                srcValid;
    // Memory port
    logic                memCe;
    logic                memRd;
    logic [MPP_AW-1:0]   memAddr;
    logic [MPP_DW-1:0]   memRdata;
    // Events
    logic                privExc;
    logic                memFault;
    modport unit (
        input  privWrValid, privWrData, ldrWrValid, appWrValid, pageWrData,
        input  execSrc, instructionPointer, actValid, actTarget, actAddr,
        input  actIsCode, srcUse, memRdata,
        output privDeny, privLevel, srcData, srcValid, memCe, memRd, memAddr,
        output privExc, memFault
    );
    modport core (
        output privWrValid, privWrData, ldrWrValid, appWrValid, pageWrData,
        output execSrc, instructionPointer, actValid, actTarget, actAddr,
        output actIsCode, srcUse, memRdata,
        input  privDeny, privLevel, srcData, srcValid, memCe, memRd, memAddr,
        input  privExc, memFault
    );
endinterface

// File: hw/mpp_core_end.sv
// Core end: turns user-side requests into link signals
`timescale 1ns/10ps
module mpp_core_end (
    // Clock and reset
    input  wire logic core_clk,
    input  wire logic rst_n,
    // Link to the protection unit
    mpp_link_if.core  lnk,
    // User side requests
    input  wire logic                          reqPrivWr,
    input  wire logic [mpp_pkg::MPP_PVW-1:0]   reqPrivData,
    input  wire logic                          reqLdrWr,
    input  wire logic                          reqAppWr,
    input  wire logic [mpp_pkg::MPP_PGW-1:0]   reqPage,
    input  wire mpp_pkg::mpp_src_t             reqSrc,
    input  wire logic [mpp_pkg::MPP_AW-1:0]    reqIp,
    input  wire logic                          reqAct,
    input  wire mpp_pkg::mpp_tgt_t             reqTarget,
    input  wire logic [mpp_pkg::MPP_AW-1:0]    reqAddr,
    input  wire logic                          reqCode,
    input  wire logic                          reqSrcUse,
    input  wire logic [mpp_pkg::MPP_DW-1:0]    memData,
    // User side results
    output logic [mpp_pkg::MPP_DW-1:0]         dstData,
    output logic                               dstValid,
    output logic                               denied,
    output logic                               exceptionSeen
);
    import mpp_pkg::*;

    // Requests pass straight out; the core keeps its own ordering
    assign lnk.privWrValid        = reqPrivWr;
    assign lnk.privWrData         = reqPrivData;
    assign lnk.ldrWrValid         = reqLdrWr;
    assign lnk.appWrValid         = reqAppWr;
    assign lnk.pageWrData         = reqPage;
    assign lnk.execSrc            = reqSrc;
    assign lnk.instructionPointer = reqIp;
    assign lnk.actValid           = reqAct;
    assign lnk.actTarget          = reqTarget;
    assign lnk.actAddr            = reqAddr;
    assign lnk.actIsCode          = reqCode;
    assign lnk.srcUse             = reqSrcUse;
    assign lnk.memRdata           = memData;

    // Destination register capture
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            dstData  <= '0;
            dstValid <= 1'b0;
        end else begin
            dstValid <= lnk.srcValid;
            if (lnk.srcValid) begin
                dstData <= lnk.srcData;
            end
        end
    end

    // Denial and event status
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            denied        <= 1'b0;
            exceptionSeen <= 1'b0;
        end else begin
            denied        <= lnk.privDeny;
            exceptionSeen <= lnk.privExc || lnk.memFault;
        end
    end
endmodule

// File: testbench/mpp_props.sv
// Concurrent checks on the link between the core end and the protection unit
`timescale 1ns/10ps
module mpp_props (
    // Clock and reset
    input wire logic                          core_clk,
    input wire logic                          rst_n,
    // Link signals
    input wire logic                          privWrValid,
    input wire logic                          privDeny,
    input wire logic [mpp_pkg::MPP_PVW-1:0]   privLevel,
    input wire mpp_pkg::mpp_src_t             execSrc,
    input wire logic                          actValid,
    input wire mpp_pkg::mpp_tgt_t             actTarget,
    input wire logic [mpp_pkg::MPP_AW-1:0]    actAddr,
    input wire logic                          actIsCode,
    input wire logic                          srcUse,
    input wire logic                          memCe,
    input wire logic                          memRd,
    input wire logic [mpp_pkg::MPP_AW-1:0]    memAddr,
    input wire logic                          privExc,
    input wire logic                          memFault,
    // Unit boot side
    input wire logic                          faultIntEn,
    input wire logic                          protect_enable,
    input wire logic                          debugSysLock,
    input wire logic [mpp_pkg::MPP_PGW-1:0]   loaderPage
);
    import mpp_pkg::*;
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (!rst_n);
    // Activation and system page decode
    logic act;
    logic sysDeny;
    assign act     = actValid && (actTarget != MPP_TGT_NONE);
    assign sysDeny = (actAddr[15:8] < loaderPage) && !privLevel[MPP_BIT_SYS_RD];
    // Steps of a granted, faulted or denied activation
    sequence s_grant;
        memCe ##1 !memFault;
    endsequence
    sequence s_fault;
        !memCe ##1 (memFault == faultIntEn);
    endsequence
    sequence s_deny;
        !memCe ##1 privExc;
    endsequence
    a_deny_exc:
    assert property (privWrValid && privDeny |=> privExc) else $error("deny without exception");
    a_level_no_raise:
    assert property ($past(rst_n) && !$past(privWrValid) |-> (privLevel & ~$past(privLevel)) == 4'h0)
        else $error("level gained bits");
    a_ram_level_low:
    assert property ($past(rst_n) && $past(execSrc) == MPP_SRC_RAM |-> privLevel == MPP_PRIV_LOW)
        else $error("level above low in ram");
    a_mem_read:
    assert property (memCe |-> memRd && act && memAddr == actAddr) else $error("bad memory read");
    a_open_range:
    assert property (act && execSrc == MPP_SRC_FLASH && !actIsCode && actAddr <= MPP_OPEN_TOP
        |-> s_grant) else $error("open range checked");
    a_ram_fault:
    assert property (act && protect_enable && execSrc == MPP_SRC_RAM && !actIsCode
        && actAddr <= MPP_OPEN_TOP && sysDeny |-> s_fault) else $error("ram fault missed");
    a_code_sys:
    assert property (act && protect_enable && actIsCode && sysDeny |-> s_deny)
        else $error("system code read allowed");
    a_off_free:
    assert property (act && !protect_enable |-> s_grant) else $error("fault while disabled");
    a_src_no_read:
    assert property (srcUse && !actValid |-> !memCe) else $error("source use read memory");
    a_debug_lock:
    assert property (debugSysLock == protect_enable) else $error("debug lock mismatch");
    a_enable_kept:
    assert property ($fell(protect_enable) |-> $past(execSrc) == MPP_SRC_ROM
        && $past(privLevel) == MPP_PRIV_HIGH) else $error("enable dropped");
endmodule

// File: testbench/memory_privilege_protection_test.sv
// Self-checking bench driving the core end and boot inputs of the protection unit
`timescale 1ns/10ps
module memory_privilege_protection_test;
    import mpp_pkg::*;
    // Stimulus and observed signals
    logic               core_clk = 1'b0;
    logic               rst_n = 1'b0;
    logic               pwBlankClr = 1'b0;
    logic               faultIntEn = 1'b1;
    logic               reqPrivWr = 1'b0, reqLdrWr = 1'b0, reqAppWr = 1'b0;
    logic               reqAct = 1'b0, reqCode = 1'b0, reqSrcUse = 1'b0;
    logic [MPP_PVW-1:0] reqPrivData = 4'h0;
    logic [MPP_PGW-1:0] reqPage = 8'h00, loaderPage, appPage;
    mpp_src_t           reqSrc = MPP_SRC_ROM;
    mpp_tgt_t           reqTarget = MPP_TGT_NONE;
    logic [MPP_AW-1:0]  reqIp = 16'h8000, reqAddr = 16'h0000;
    logic [MPP_DW-1:0]  memData = 16'h0000, dstData, gotDst;
    logic               dstValid, denied, exceptionSeen, protect_enable, debugSysLock;
    logic               sawExc, sawCe, sawDst, sawDen, sawFlt;
    int                 failures = 0, testsRun = 0;
    mpp_tgt_t           tgts [5] = '{MPP_TGT_DP0, MPP_TGT_DP1, MPP_TGT_BASE, MPP_TGT_DISP,
                                     MPP_TGT_CTRL};
    always #2.5 core_clk = ~core_clk;
    // Both ends joined by the link
    mpp_link_if lnk ();
    mpp_unit mpp_unit_inst (.core_clk, .rst_n, .lnk(lnk), .pwBlankClr, .faultIntEn,
        .protect_enable, .debugSysLock, .loaderPage, .appPage);
    mpp_core_end mpp_core_end_inst (.core_clk, .rst_n, .lnk(lnk), .reqPrivWr, .reqPrivData,
        .reqLdrWr, .reqAppWr, .reqPage, .reqSrc, .reqIp, .reqAct, .reqTarget, .reqAddr,
        .reqCode, .reqSrcUse, .memData, .dstData, .dstValid, .denied, .exceptionSeen);
    mpp_props mpp_props_inst (.core_clk, .rst_n, .privWrValid(lnk.privWrValid),
        .privDeny(lnk.privDeny), .privLevel(lnk.privLevel), .execSrc(lnk.execSrc),
        .actValid(lnk.actValid), .actTarget(lnk.actTarget), .actAddr(lnk.actAddr),
        .actIsCode(lnk.actIsCode), .srcUse(lnk.srcUse), .memCe(lnk.memCe),
        .memRd(lnk.memRd), .memAddr(lnk.memAddr), .privExc(lnk.privExc),
        .memFault(lnk.memFault), .faultIntEn, .protect_enable, .debugSysLock, .loaderPage);
    // Value comparison
    task automatic cmp(input string what, input logic [15:0] exp, input logic [15:0] got);
        testsRun++;
        if (got !== exp) begin
            failures++;
            $display("wrong value %s expected %h seen %h", what, exp, got);
        end
    endtask
    // Samples results mid-cycle, drops every request pulse after its edge
    task automatic watch(input int n);
        sawExc = 1'b0;
        sawCe = 1'b0;
        sawDst = 1'b0;
        sawDen = 1'b0;
        sawFlt = 1'b0;
        repeat (n) begin
            @(negedge core_clk);
            if (exceptionSeen === 1'b1) sawExc = 1'b1;
            if (lnk.memCe === 1'b1) sawCe = 1'b1;
            if (denied === 1'b1) sawDen = 1'b1;
            if (lnk.memFault === 1'b1) sawFlt = 1'b1;
            if (dstValid === 1'b1) begin
                sawDst = 1'b1;
                gotDst = dstData;
            end
            @(posedge core_clk);
            #1;
            {reqPrivWr, reqLdrWr, reqAppWr, reqAct, reqSrcUse} = 5'h00;
        end
    endtask
    // Pointer activation with the memory word on offer
    task automatic act(input mpp_src_t s, input mpp_tgt_t t, input logic [15:0] a,
                       input logic c, input logic [15:0] d);
        reqSrc = s;
        reqTarget = t;
        reqAddr = a;
        reqCode = c;
        memData = d;
        reqAct = 1'b1;
        watch(6);
    endtask
    // Pointer named as source
    task automatic use_src(input logic ok, input logic [15:0] d);
        reqSrcUse = 1'b1;
        watch(5);
        cmp("dst valid", ok, sawDst);
        if (ok) cmp("dst data", d, gotDst);
    endtask
    // Verdict
    task automatic tallyAndFinish();
        $display("comparisons %0d mismatches %0d", testsRun, failures);
        if (failures == 0 && testsRun > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask
    // Main sequence
    initial begin
        repeat (2) @(posedge core_clk);
        #1;
        rst_n = 1'b1;
        cmp("level", MPP_PRIV_HIGH, lnk.privLevel);
        cmp("enable", 1'b1, protect_enable);
        cmp("debug lock", 1'b1, debugSysLock);
        cmp("loader page", MPP_PAGE_RST, loaderPage);
        // Startup code sets both boundaries at high level
        reqPage = 8'h20;
        reqLdrWr = 1'b1;
        watch(2);
        reqPage = 8'h40;
        reqAppWr = 1'b1;
        watch(3);
        cmp("loader page", 8'h20, loaderPage);
        cmp("app page", 8'h40, appPage);
        // Loader area lowers the level to medium
        reqSrc = MPP_SRC_FLASH;
        reqIp = 16'h3000;
        watch(3);
        cmp("level", MPP_PRIV_MED, lnk.privLevel);
        // Loader code asking for the system read bit is refused whole
        reqPrivData = 4'h4;
        reqPrivWr = 1'b1;
        watch(4);
        cmp("denied", 1'b1, sawDen);
        cmp("exception", 1'b1, sawExc);
        cmp("level", MPP_PRIV_MED, lnk.privLevel);
        // Application code writing high is refused
        reqIp = 16'h5000;
        reqPrivData = MPP_PRIV_HIGH;
        reqPrivWr = 1'b1;
        watch(6);
        cmp("exception", 1'b1, sawExc);
        cmp("denied", 1'b1, sawDen);
        cmp("level", MPP_PRIV_LOW, lnk.privLevel);
        reqPage = 8'h10;
        reqLdrWr = 1'b1;
        watch(3);
        cmp("loader page", 8'h20, loaderPage);
        // Flash routine reads low range unchecked
        act(MPP_SRC_FLASH, MPP_TGT_DP0, 16'h0010, 1'b0, 16'h1234);
        cmp("exception", 1'b0, sawExc);
        cmp("fault", 1'b0, sawFlt);
        cmp("mem read", 1'b1, sawCe);
        use_src(1'b1, 16'h1234);
        // RAM code activating any pointer into system space
        foreach (tgts[i]) begin
            act(MPP_SRC_RAM, tgts[i], 16'h0010, 1'b0, 16'h5a5a);
            cmp("exception", 1'b1, sawExc);
            cmp("mem read", 1'b0, sawCe);
            cmp("fault", 1'b1, sawFlt);
        end
        // Fault interrupt disabled: still denied, no fault event
        faultIntEn = 1'b0;
        act(MPP_SRC_RAM, MPP_TGT_DP0, 16'h0010, 1'b0, 16'h5a5a);
        cmp("fault", 1'b0, sawFlt);
        cmp("mem read", 1'b0, sawCe);
        faultIntEn = 1'b1;
        use_src(1'b0, 16'h0000);
        act(MPP_SRC_FLASH, MPP_TGT_DP1, 16'h0100, 1'b1, 16'h0f0f);
        cmp("exception", 1'b1, sawExc);
        cmp("fault", 1'b0, sawFlt);
        // Boot code with blank password clears the enable
        reqSrc = MPP_SRC_ROM;
        reqIp = 16'h8000;
        reqPrivData = MPP_PRIV_HIGH;
        reqPrivWr = 1'b1;
        watch(4);
        cmp("denied", 1'b0, sawDen);
        pwBlankClr = 1'b1;
        watch(3);
        pwBlankClr = 1'b0;
        cmp("enable", 1'b0, protect_enable);
        cmp("debug lock", 1'b0, debugSysLock);
        act(MPP_SRC_RAM, MPP_TGT_DP0, 16'h0010, 1'b0, 16'h7e7e);
        cmp("exception", 1'b0, sawExc);
        cmp("fault", 1'b0, sawFlt);
        use_src(1'b1, 16'h7e7e);
        tallyAndFinish();
    end
endmodule
